// ### frc_cfg.svh
`ifndef FRC_CFG_SVH
`define FRC_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_CTRL 16'h1880
`define IDX_CNT_HI 16'h1881
`define IDX_CNT_LO 16'h1882
`define IDX_CMP_HI 16'h1883
`define IDX_CMP_LO 16'h1884

// Field positions in counter_control_status.
`define BIT_COUNT_CLEAR 7
`define BIT_RUN_ENABLE 5
`define BIT_CMP_IRQ_ENABLE 4
`define BIT_CMP_IRQ_ACK 3
`define BIT_CMP_IRQ_FLAG 2

// Reset values.
`define RST_COUNT 16'h0000
`define RST_COMPARE 16'hFFFF
`define RST_CTRL 8'h00

// Synchroniser depth for pins from outside the clock domain.
`define SYNC_STAGES 3

`endif

// ### free_running_counter_pkg.sv
`default_nettype none

package free_running_counter_pkg;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } sync_state_s;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] compare;
      logic runEnable;
      logic cmpIrqEnable;
      logic cmpIrqFlag;
      logic cmpIrq;
      apb_rsp_s rsp;
   } frc_state_s;

endpackage

`default_nettype wire

// ### osc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser with an agreement filter and a rise detector.
// The first stage feeds only the second stage.
module osc_sync
   import free_running_counter_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic pinIn,
   output logic level,
   output logic rise
);

   sync_state_s q;
   sync_state_s d;

   always_comb begin
      d = q;
      d.s1 = pinIn;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.rise = 1'b0;
      if (q.s2 == q.s3) begin
         d.level = q.s3;
         d.rise = q.s3 & ~q.level;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign level = q.level;
   assign rise = q.rise;

endmodule // osc_sync

`default_nettype wire

// ### count_compare.sv
`timescale 1ns/1ps
`default_nettype none

// Compares the running count against the programmed target.
module count_compare
   import free_running_counter_pkg::*;
(
   input wire logic [15:0] count,
   input wire logic [15:0] target,
   output logic equal,
   output logic atOrPast
);

   always_comb begin
      equal = (count == target);
      atOrPast = (count >= target);
   end

endmodule // count_compare

`default_nettype wire

// ### free_running_counter_compare.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

`include "frc_cfg.svh"

module free_running_counter_compare
   import free_running_counter_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic porRst,
   input wire logic ce,
   input wire logic slowOscIn,
   input wire logic fastOscIn,
   input wire logic testModeIn,
   input wire apb_req_s apbReq,
   output apb_rsp_s apbRsp,
   output logic cmpIrq,
   output logic cmpEvent,
   output logic runHold
);

   frc_state_s q;
   frc_state_s d;
   logic slowRise;
   logic fastRise;
   logic testMode;
   logic tick;
   logic cntEqual;
   logic cntAtOrPast;
   logic eventQ;
   logic setupPhase;
   logic writeTaken;
   logic addrHit;
   logic [15:0] regIndex;
   logic [7:0] readByte;
   logic [7:0] wByte;

   // Oscillator and mode pins are asynchronous; each passes three stages.
   osc_sync slowSync (
      .clk(clk),
      .rst(porRst),
      .ce(ce),
      .pinIn(slowOscIn),
      .level(),
      .rise(slowRise)
   );

   osc_sync fastSync (
      .clk(clk),
      .rst(porRst),
      .ce(ce),
      .pinIn(fastOscIn),
      .level(),
      .rise(fastRise)
   );

   osc_sync modeSync (
      .clk(clk),
      .rst(porRst),
      .ce(ce),
      .pinIn(testModeIn),
      .level(testMode),
      .rise()
   );

   count_compare cmpUnit (
      .count(q.count),
      .target(q.compare),
      .equal(cntEqual),
      .atOrPast(cntAtOrPast)
   );

   // A fast oscillator above a quarter of clk loses ticks in the sampler;
   // the trade keeps the whole block on one clock.
   always_comb begin
      tick = testMode ? fastRise : slowRise;
   end

   // Bus decode: the index is the byte address divided by four.
   always_comb begin
      regIndex = {2'b00, apbReq.paddr[15:2]};
      setupPhase = apbReq.psel & ~apbReq.penable;
      writeTaken = apbReq.psel & apbReq.penable & q.rsp.pready &
         apbReq.pwrite & ~q.rsp.pslverr;
      wByte = apbReq.pwdata[7:0];
      addrHit = 1'b1;
      readByte = 8'h00;
      case (regIndex)
         `IDX_CTRL: begin
            readByte[`BIT_RUN_ENABLE] = q.runEnable;
            readByte[`BIT_CMP_IRQ_ENABLE] = q.cmpIrqEnable;
            readByte[`BIT_CMP_IRQ_FLAG] = q.cmpIrqFlag;
            // Clear and acknowledge stay 0 on read.
         end
         `IDX_CNT_HI: begin
            readByte = q.count[15:8];
         end
         `IDX_CNT_LO: begin
            readByte = q.count[7:0];
         end
         `IDX_CMP_HI: begin
            readByte = q.compare[15:8];
         end
         `IDX_CMP_LO: begin
            readByte = q.compare[7:0];
         end
         default: begin
            addrHit = 1'b0;
         end
      endcase
   end

   always_comb begin
      d = q;
      eventQ = cntEqual;

      // Answer is prepared during setup so the access phase needs no wait.
      d.rsp.pready = 1'b0;
      d.rsp.pslverr = 1'b0;
      if (setupPhase) begin
         d.rsp.pready = 1'b1;
         d.rsp.pslverr = ~addrHit;
         d.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : {24'h000000, readByte};
      end

      // Counting advances on each tick while runEnable is set; ce low holds it.
      if (q.runEnable && tick) begin
         d.count = q.count + 16'h0001;
      end

      if (writeTaken) begin
         case (regIndex)
            `IDX_CTRL: begin
               d.runEnable = wByte[`BIT_RUN_ENABLE];
               d.cmpIrqEnable = wByte[`BIT_CMP_IRQ_ENABLE];
               if (wByte[`BIT_COUNT_CLEAR]) begin
                  d.count = `RST_COUNT;
               end
               if (wByte[`BIT_COUNT_CLEAR] || !wByte[`BIT_RUN_ENABLE]) begin
                  d.cmpIrqEnable = 1'b0;
               end
               if (wByte[`BIT_CMP_IRQ_ACK]) begin
                  d.cmpIrqFlag = 1'b0;
               end
            end
            `IDX_CMP_HI: begin
               d.compare[15:8] = wByte;
            end
            `IDX_CMP_LO: begin
               d.compare[7:0] = wByte;
            end
            default: begin
               d.count = d.count;
            end
         endcase
      end

      // Setting is placed after the acknowledge so a same-cycle event wins.
      if (q.cmpIrqEnable && cntAtOrPast) begin
         d.cmpIrqFlag = 1'b1;
      end
      d.cmpIrq = d.cmpIrqFlag & d.cmpIrqEnable;
   end

   logic eventR;

   always_ff @(posedge clk) begin
      if (porRst) begin
         q.count <= `RST_COUNT;
         q.compare <= `RST_COMPARE;
         q.runEnable <= 1'b0;
         q.cmpIrqEnable <= 1'b0;
         q.cmpIrqFlag <= 1'b0;
         q.cmpIrq <= 1'b0;
         q.rsp <= '0;
         eventR <= 1'b0;
      end else if (rst) begin
         // Count and run state survive resets other than power-on.
         q.compare <= `RST_COMPARE;
         q.cmpIrqEnable <= 1'b0;
         q.cmpIrqFlag <= 1'b0;
         q.cmpIrq <= 1'b0;
         q.rsp <= '0;
         eventR <= 1'b0;
      end else if (ce) begin
         q <= d;
         eventR <= eventQ & q.cmpIrqEnable;
      end
   end

   assign apbRsp = q.rsp;
   assign cmpIrq = q.cmpIrq;
   assign cmpEvent = eventR;
   assign runHold = q.runEnable;

endmodule // free_running_counter_compare

`default_nettype wire

// ### frc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module frc_asserts
   import free_running_counter_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic porRst,
   input wire logic ce,
   input wire logic slowOscIn,
   input wire logic fastOscIn,
   input wire logic testModeIn,
   input wire apb_req_s apbReq,
   input wire apb_rsp_s apbRsp,
   input wire logic cmpIrq,
   input wire logic cmpEvent,
   input wire logic runHold
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst || porRst);
   logic ac;
   logic wc;
   assign ac = apbRsp.pready;
   assign wc = ac && apbReq.pwrite && apbReq.paddr == 16'h6200;
   sequence s_set;
      ce && apbReq.psel && !apbReq.penable;
   endsequence
   sequence s_acc;
      ac ##1 !ac;
   endsequence
   property p_rdy;
      s_set |=> s_acc;
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready missing");
   property p_ctl;
      ac && !apbReq.pwrite && apbReq.paddr == 16'h6200
         |-> (apbRsp.prdata & ~32'h34) == 32'h0;
   endproperty
   a_ctl: assert property (p_ctl) else $error("ctrl bits");
   property p_err;
      ac && !(apbReq.paddr inside {16'h6200, 16'h6204, 16'h6208,
         16'h620C, 16'h6210}) |-> apbRsp.pslverr && apbRsp.prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("unmapped");
   property p_wz;
      ac && apbReq.pwrite |-> apbRsp.prdata == 32'h0;
   endproperty
   a_wz: assert property (p_wz) else $error("write data");
   property p_off;
      wc && (apbReq.pwdata[7] || !apbReq.pwdata[5]) |-> ##2 !cmpIrq;
   endproperty
   a_off: assert property (p_off) else $error("irq kept");
   property p_run;
      wc |-> ##2 runHold == $past(apbReq.pwdata[5], 2);
   endproperty
   a_run: assert property (p_run) else $error("run state");
   property p_evt;
      $rose(cmpEvent) |-> ##[0:2] cmpIrq;
   endproperty
   a_evt: assert property (p_evt) else $error("no irq");
   property p_por;
      disable iff (1'b0) porRst |=> !runHold && !cmpIrq && !cmpEvent;
   endproperty
   a_por: assert property (p_por) else $error("por");
endmodule // frc_asserts
bind free_running_counter_compare frc_asserts chk (.clk(clk), .rst(rst),
   .porRst(porRst), .ce(ce), .slowOscIn(slowOscIn), .fastOscIn(fastOscIn),
   .testModeIn(testModeIn), .apbReq(apbReq), .apbRsp(apbRsp),
   .cmpIrq(cmpIrq), .cmpEvent(cmpEvent), .runHold(runHold));
`default_nettype wire

// ### osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Oscillator pins with a phase unrelated to the bus clock.
module osc_model
(
   input wire logic slowOn,
   input wire logic fastOn,
   output logic slowOsc,
   output logic fastOsc
);
   initial begin
      slowOsc = 1'b0;
      #7;
      forever #230 slowOsc = slowOn & ~slowOsc;
   end
   initial begin
      fastOsc = 1'b0;
      forever #60 fastOsc = fastOn & ~fastOsc;
   end
endmodule // osc_model
`default_nettype wire

// ### free_running_counter_compare_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module free_running_counter_compare_tb_top
   import free_running_counter_pkg::*;
;
   localparam logic [15:0] CT = 16'h6200;
   logic clk, rst, porRst, ce, tm, slowOn, slowOsc, fastOsc, e;
   logic cmpIrq, cmpEvent, runHold;
   logic [7:0] s;
   logic [31:0] r;
   apb_req_s req;
   apb_rsp_s rsp;
   int mismatches, total_checks, i;
   free_running_counter_compare dut (.clk(clk), .rst(rst), .porRst(porRst),
      .ce(ce), .slowOscIn(slowOsc), .fastOscIn(fastOsc), .testModeIn(tm),
      .apbReq(req), .apbRsp(rsp), .cmpIrq(cmpIrq), .cmpEvent(cmpEvent),
      .runHold(runHold));
   osc_model osc (.slowOn(slowOn), .fastOn(1'b1), .slowOsc(slowOsc),
      .fastOsc(fastOsc));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] x, g);
      total_checks++;
      if (g !== x) begin
         mismatches++;
         $display("CHECK FAILED %s exp %0h got %0h", n, x, g);
      end
   endtask
   // The answer is taken at the rising edge that sees pready high.
   task automatic apb(input logic w, input logic [15:0] a,
      input logic [7:0] d);
      int n;
      req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (rsp.pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            mismatches++;
            report_and_stop();
         end
         @(posedge clk);
      end
      r = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input string n, input logic [15:0] a,
      input logic [31:0] x);
      apb(1'b0, a, 8'h0);
      chk(n, x, r);
   endtask
   initial begin
      req = '0;
      ce = 1'b1;
      rst = 1'b1;
      porRst = 1'b1;
      tm = 1'b0;
      slowOn = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      porRst <= 1'b0;
      @(posedge clk);
      rd("ctrl", CT, 32'h0);
      rd("cmpHi", CT + 16'hC, 32'hFF);
      rd("cmpLo", CT + 16'h10, 32'hFF);
      rd("cntHi", CT + 16'h4, 32'h0);
      rd("cntLo", CT + 16'h8, 32'h0);
      rd("bad", CT + 16'h14, 32'h0);
      chk("err", 32'h1, {31'h0, e});
      apb(1'b1, CT + 16'hC, 8'h0);
      apb(1'b1, CT + 16'h10, 8'h05);
      rd("cmpHi", CT + 16'hC, 32'h0);
      rd("cmpLo", CT + 16'h10, 32'h5);
      apb(1'b1, CT, 8'h08);
      apb(1'b1, CT, 8'h20);
      apb(1'b1, CT, 8'h30);
      for (i = 0; i < 100 && r[2] !== 1'b1; i++)
         apb(1'b0, CT, 8'h0);
      chk("flag", 32'h34, r);
      chk("irq", 32'h1, {31'h0, cmpIrq});
      apb(1'b1, CT, 8'h38);
      rd("reflag", CT, 32'h34);
      apb(1'b1, CT, 8'h20);
      apb(1'b1, CT, 8'h28);
      rd("acked", CT, 32'h20);
      apb(1'b1, CT, 8'h30);
      apb(1'b1, CT, 8'hB0);
      rd("clrCtl", CT, 32'h24);
      rd("clearHi", CT + 16'h4, 32'h0);
      apb(1'b0, CT + 16'h8, 8'h0);
      chk("small", 32'h1, {31'h0, r < 32'h2});
      repeat (100) @(posedge clk);
      rd("runsHi", CT + 16'h4, 32'h0);
      apb(1'b0, CT + 16'h8, 8'h0);
      chk("moving", 32'h1, {31'h0, r > 32'h2});
      s = r[7:0];
      ce <= 1'b0;
      repeat (100) @(posedge clk);
      ce <= 1'b1;
      apb(1'b0, CT + 16'h8, 8'h0);
      chk("ceHold", 32'h1, {31'h0, 8'(r[7:0] - s) < 8'h3});
      apb(1'b1, CT, 8'h10);
      rd("halt", CT, 32'h04);
      apb(1'b0, CT + 16'h8, 8'h0);
      s = r[7:0];
      repeat (50) @(posedge clk);
      rd("frozen", CT + 16'h8, {24'h0, s});
      apb(1'b1, CT, 8'h20);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd("rstCtl", CT, 32'h20);
      rd("rstCmp", CT + 16'h10, 32'hFF);
      slowOn <= 1'b0;
      tm <= 1'b1;
      apb(1'b0, CT + 16'h8, 8'h0);
      s = r[7:0];
      repeat (40) @(posedge clk);
      apb(1'b0, CT + 16'h8, 8'h0);
      chk("fast", 32'h1, {31'h0, 8'(r[7:0] - s) > 8'h5});
      report_and_stop();
   end
endmodule // free_running_counter_compare_tb_top
`default_nettype wire
